// ===== rtl/seq_cfg_peak_regs.sv
// Functional notes
// - Primary fault pin low stops primary globals
// - Averaging field picks 1, 2, 4, 8 samples
// - Secondary fault pin low stops secondary globals
// - Alarm clear drops alarms, then self-clears
// - Bit 7 selects push-pull or open-drain
// - Bit 6 selects active-low or active-high
// - Override forces fixed level, GPO use
// - Reserved configuration bits read as zero
// - Event mode maps outputs onto timeslots
// - Group bit used only in dual mode
// - Slot codes 0 to 11, rest reserved
// - Voltage peak: writes set comparison base
// - Temperature peak: 8000h resets to lowest
// - Voltage minimum: 7FFFh resets it
// - Average temperature: only zero write resets
// - Statistics are two-byte direct-format words
// - Mode bit selects time or event sequencing
// - Mode bit selects one or two groups
module seq_cfg_peak_regs #(
    parameter int CHANNELS = seq_regs_pkg::CHANNELS
) (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clock_en,
    // Decoded command port and answer
    input wire seq_regs_pkg::cmd_t i_cmd,
    output seq_regs_pkg::rsp_t o_rsp,
    // Measurements from the converter
    input wire seq_regs_pkg::meas_t i_meas,
    // Fault pins, active low, asynchronous
    input wire logic i_primary_fault_pin_n,
    input wire logic i_secondary_fault_pin_n,
    // Fault and sequencer inputs
    input wire logic [CHANNELS-1:0] i_channel_global,
    input wire logic [CHANNELS-1:0] i_supply_on,
    input wire logic i_alarm_a_set,
    input wire logic i_alarm_b_set,
    // Supply enable pins
    output logic [CHANNELS-1:0] o_supply_enable_out,
    output logic [CHANNELS-1:0] o_supply_enable_oe,
    // Alarm outputs
    output logic o_alarm_output_a,
    output logic o_alarm_output_b,
    // Shutdown requests
    output logic o_primary_shutdown,
    output logic o_secondary_shutdown,
    output logic [CHANNELS-1:0] o_channel_shutdown,
    // Sequencing configuration
    output logic o_sequencing_mode_select,
    output logic o_two_group_sequencing,
    output logic [3:0] o_adc_average_samples,
    output logic [CHANNELS-1:0][3:0] o_slot_code,
    output logic [CHANNELS-1:0] o_slot_active,
    output logic [CHANNELS-1:0] o_group_secondary
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] mode;
        logic [CHANNELS-1:0][7:0] en_cfg;
        logic [CHANNELS-1:0][7:0] slot;
        logic [CHANNELS-1:0][15:0] vpeak;
        logic [CHANNELS-1:0][15:0] vmin;
        logic [15:0] tpeak;
        logic [15:0] tavg;
        logic tavg_empty;
        logic alarm_a;
        logic alarm_b;
        seq_regs_pkg::clr_state_t clr;
        seq_regs_pkg::rsp_t rsp;
    } state_t;

    state_t cur_reg;
    state_t cur_next;

    logic [1:0] fault_sync; // Synced pins, bit 0 primary
    logic signed [16:0] tdiff; // Sample minus average
    logic signed [16:0] tstep; // Scaled step
    logic meas_ok; // Measurement page in range
    logic cmd_ok; // Command page in range
    logic [3:0] mpg; // Measurement page
    logic [3:0] cpg; // Command page

    // ----------------------------------------
    // Fault pin synchroniser
    // ----------------------------------------
    level_sync #(
        .W(2)
    ) u_fault_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clock_en(i_clock_en),
        .i_async({i_secondary_fault_pin_n, i_primary_fault_pin_n}),
        .o_sync(fault_sync)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        cur_next = cur_reg;
        cur_next.rsp = '0;
        mpg = i_meas.page;
        cpg = i_cmd.page;
        meas_ok = int'(i_meas.page) < CHANNELS;
        cmd_ok = int'(i_cmd.page) < CHANNELS;
        tdiff = 17'($signed(i_meas.temp)) - 17'($signed(cur_reg.tavg));
        tstep = tdiff >>> seq_regs_pkg::TAVG_SHIFT;

        // Voltage statistics per page
        if (i_meas.vout_valid && meas_ok)
        begin
            if ($signed(i_meas.vout) > $signed(cur_reg.vpeak[mpg]))
                cur_next.vpeak[mpg] = i_meas.vout;
            if ($signed(i_meas.vout) < $signed(cur_reg.vmin[mpg]))
                cur_next.vmin[mpg] = i_meas.vout;
        end

        // Temperature peak and running average
        if (i_meas.temp_valid)
        begin
            if ($signed(i_meas.temp) > $signed(cur_reg.tpeak))
                cur_next.tpeak = i_meas.temp;
            if (cur_reg.tavg_empty)
                cur_next.tavg = i_meas.temp;
            else
                cur_next.tavg = cur_reg.tavg + tstep[15:0];
            cur_next.tavg_empty = 1'b0;
        end

        // Alarm clear sequence
        case (cur_reg.clr)
            seq_regs_pkg::CLR_BUSY:
            begin
                cur_next.alarm_a = 1'b0;
                cur_next.alarm_b = 1'b0;
                cur_next.mode[seq_regs_pkg::MODE_CLR_BIT] = 1'b0;
                cur_next.clr = seq_regs_pkg::CLR_IDLE;
            end
            default:
                cur_next.clr = seq_regs_pkg::CLR_IDLE;
        endcase

        // Alarm events win over the clear
        if (i_alarm_a_set)
            cur_next.alarm_a = 1'b1;
        if (i_alarm_b_set)
            cur_next.alarm_b = 1'b1;

        // Writes win over same-cycle measurements
        if (i_cmd.valid && i_cmd.write)
        begin
            if (i_cmd.code == seq_regs_pkg::CMD_MODE)
            begin
                cur_next.mode = i_cmd.wdata & seq_regs_pkg::MODE_MASK;
                if (i_cmd.wdata[seq_regs_pkg::MODE_CLR_BIT])
                    cur_next.clr = seq_regs_pkg::CLR_BUSY;
            end
            else if (i_cmd.code == seq_regs_pkg::CMD_EN_CFG && cmd_ok)
                cur_next.en_cfg[cpg] = i_cmd.wdata[7:0] & seq_regs_pkg::EN_MASK;
            else if (i_cmd.code == seq_regs_pkg::CMD_SLOT && cmd_ok)
                cur_next.slot[cpg] = i_cmd.wdata[7:0] & seq_regs_pkg::SLOT_MASK;
            else if (i_cmd.code == seq_regs_pkg::CMD_VPEAK && cmd_ok)
                cur_next.vpeak[cpg] = i_cmd.wdata;
            else if (i_cmd.code == seq_regs_pkg::CMD_TPEAK)
                cur_next.tpeak = i_cmd.wdata;
            else if (i_cmd.code == seq_regs_pkg::CMD_VMIN && cmd_ok)
                cur_next.vmin[cpg] = i_cmd.wdata;
            else if (i_cmd.code == seq_regs_pkg::CMD_TAVG)
            begin
                // Only a zero write restarts the average
                if (i_cmd.wdata == seq_regs_pkg::TAVG_RESET)
                begin
                    cur_next.tavg = seq_regs_pkg::TAVG_RESET;
                    cur_next.tavg_empty = 1'b1;
                end
            end
            else
                cur_next.rsp.unmapped = 1'b1;
            cur_next.rsp.valid = 1'b1;
        end
        else if (i_cmd.valid)
        begin
            // Reads: two-byte words
            cur_next.rsp.valid = 1'b1;
            if (i_cmd.code == seq_regs_pkg::CMD_MODE)
                cur_next.rsp.data = cur_reg.mode;
            else if (i_cmd.code == seq_regs_pkg::CMD_EN_CFG && cmd_ok)
                cur_next.rsp.data = {8'h00, cur_reg.en_cfg[cpg]};
            else if (i_cmd.code == seq_regs_pkg::CMD_SLOT && cmd_ok)
                cur_next.rsp.data = {8'h00, cur_reg.slot[cpg]};
            else if (i_cmd.code == seq_regs_pkg::CMD_VPEAK && cmd_ok)
                cur_next.rsp.data = cur_reg.vpeak[cpg];
            else if (i_cmd.code == seq_regs_pkg::CMD_TPEAK)
                cur_next.rsp.data = cur_reg.tpeak;
            else if (i_cmd.code == seq_regs_pkg::CMD_VMIN && cmd_ok)
                cur_next.rsp.data = cur_reg.vmin[cpg];
            else if (i_cmd.code == seq_regs_pkg::CMD_TAVG)
                cur_next.rsp.data = cur_reg.tavg;
            else
                cur_next.rsp.unmapped = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cur_reg.mode <= seq_regs_pkg::MODE_RESET;
            cur_reg.en_cfg <= {CHANNELS{seq_regs_pkg::EN_RESET}};
            cur_reg.slot <= {CHANNELS{seq_regs_pkg::SLOT_RESET}};
            cur_reg.vpeak <= {CHANNELS{seq_regs_pkg::VPEAK_RESET}};
            cur_reg.vmin <= {CHANNELS{seq_regs_pkg::VMIN_RESET}};
            cur_reg.tpeak <= seq_regs_pkg::TPEAK_RESET;
            cur_reg.tavg <= seq_regs_pkg::TAVG_RESET;
            cur_reg.tavg_empty <= 1'b1;
            cur_reg.alarm_a <= 1'b0;
            cur_reg.alarm_b <= 1'b0;
            cur_reg.clr <= seq_regs_pkg::CLR_IDLE;
            cur_reg.rsp <= '0;
        end
        else if (i_clock_en)
            cur_reg <= cur_next;
    end

    // ----------------------------------------
    // Mode decode and fault pins
    // ----------------------------------------
    assign o_sequencing_mode_select = cur_reg.mode[seq_regs_pkg::MODE_SEQ_BIT];
    assign o_two_group_sequencing = cur_reg.mode[seq_regs_pkg::MODE_DUAL_BIT];
    // Sample count is a power of two
    assign o_adc_average_samples =
        4'(4'h1 << cur_reg.mode[seq_regs_pkg::MODE_AVG_LSB +: 2]);
    assign o_primary_shutdown =
        !fault_sync[0] && !cur_reg.mode[seq_regs_pkg::MODE_IGN1_BIT];
    assign o_secondary_shutdown =
        !fault_sync[1] && !cur_reg.mode[seq_regs_pkg::MODE_IGN2_BIT];
    assign o_alarm_output_a = cur_reg.alarm_a;
    assign o_alarm_output_b = cur_reg.alarm_b;
    assign o_rsp = cur_reg.rsp;

    // ----------------------------------------
    // Per-channel slot, group and pin
    // ----------------------------------------
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        // Group bit counts only in dual mode
        assign o_group_secondary[ch] = o_two_group_sequencing
            && cur_reg.slot[ch][seq_regs_pkg::SLOT_GROUP_BIT];
        assign o_slot_code[ch] = cur_reg.slot[ch][3:0];
        // Slot used only in event mode with a legal code
        assign o_slot_active[ch] = o_sequencing_mode_select
            && cur_reg.slot[ch][3:0] <= seq_regs_pkg::SLOT_LAST;
        // Global channels follow their group's fault pin
        assign o_channel_shutdown[ch] = i_channel_global[ch]
            && (o_group_secondary[ch] ? o_secondary_shutdown
                                       : o_primary_shutdown);

        enable_pin_driver u_pin (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_clock_en(i_clock_en),
            .i_config(cur_reg.en_cfg[ch]),
            .i_enable(i_supply_on[ch] && !o_channel_shutdown[ch]),
            .o_out(o_supply_enable_out[ch]),
            .o_oe(o_supply_enable_oe[ch])
        );
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    chk_primary_fault_stop: assert property (
        (i_clock_en && !i_primary_fault_pin_n
         && !cur_reg.mode[seq_regs_pkg::MODE_IGN1_BIT])[*3] |-> o_primary_shutdown)
        else $error("primary fault pin did not stop globals");

    chk_secondary_ignore: assert property (
        cur_reg.mode[seq_regs_pkg::MODE_IGN2_BIT] |-> !o_secondary_shutdown)
        else $error("ignored secondary pin caused shutdown");

    chk_avg_eight: assert property (
        cur_reg.mode[seq_regs_pkg::MODE_AVG_LSB +: 2] == 2'b11
        |-> o_adc_average_samples == 4'h8)
        else $error("averaging field decode wrong");

    chk_alarm_clear_done: assert property (
        (i_clock_en && cur_reg.clr == seq_regs_pkg::CLR_BUSY && !i_alarm_a_set
         && !(i_cmd.valid && i_cmd.write))
        |=> !o_alarm_output_a && !cur_reg.mode[seq_regs_pkg::MODE_CLR_BIT])
        else $error("alarm clear did not complete");

    chk_gpo_open_high: assert property (
        (i_clock_en && cur_reg.en_cfg[0] == 8'hC1) |=> !o_supply_enable_oe[0])
        else $error("open-drain forced high still driving");

    chk_gpo_push_low: assert property (
        (i_clock_en && cur_reg.en_cfg[0] == 8'h01)
        |=> o_supply_enable_oe[0] && !o_supply_enable_out[0])
        else $error("push-pull forced low not driven low");

    chk_reserved_zero: assert property (
        o_rsp.valid |-> cur_reg.en_cfg[0][5:1] == 5'h00 && cur_reg.slot[0][7:6] == 2'b00
        && cur_reg.slot[0][4] == 1'b0)
        else $error("reserved bits stored nonzero");

    chk_vpeak_write: assert property (
        (i_clock_en && i_cmd.valid && i_cmd.write && cmd_ok
         && i_cmd.code == seq_regs_pkg::CMD_VPEAK)
        |=> cur_reg.vpeak[$past(cpg)] == $past(i_cmd.wdata))
        else $error("voltage peak write not taken");

    chk_vmin_track: assert property (
        (i_clock_en && i_meas.vout_valid && meas_ok && !i_cmd.valid
         && $signed(i_meas.vout) < $signed(cur_reg.vmin[mpg]))
        |=> cur_reg.vmin[$past(mpg)] == $past(i_meas.vout))
        else $error("voltage minimum not updated");

    chk_tavg_ignore: assert property (
        (i_clock_en && i_cmd.valid && i_cmd.write && !i_meas.temp_valid
         && i_cmd.code == seq_regs_pkg::CMD_TAVG && i_cmd.wdata != 16'h0000)
        |=> $stable(cur_reg.tavg))
        else $error("nonzero average write changed value");

    chk_slot_reserved: assert property (
        o_slot_active[0] |-> o_sequencing_mode_select && o_slot_code[0] <= 4'hB)
        else $error("reserved slot code marked active");

    cov_alarm_clear: cover property (
        cur_reg.clr == seq_regs_pkg::CLR_BUSY && o_alarm_output_a);
    cov_secondary_stop: cover property (o_secondary_shutdown && o_two_group_sequencing);
    cov_gpo_mode: cover property (cur_reg.en_cfg[0][seq_regs_pkg::EN_OVR_BIT]);
    cov_tpeak_reset: cover property (
        i_cmd.valid && i_cmd.write && i_cmd.code == seq_regs_pkg::CMD_TPEAK
        && i_cmd.wdata == 16'h8000);

endmodule

// ===== rtl/seq_regs_pkg.sv
package seq_regs_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int CHANNELS = 12;
    localparam int PAGE_W = 4;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_MODE = 8'hD1;
    localparam logic [7:0] CMD_EN_CFG = 8'hD2;
    localparam logic [7:0] CMD_SLOT = 8'hD3;
    localparam logic [7:0] CMD_VPEAK = 8'hD4;
    localparam logic [7:0] CMD_TPEAK = 8'hD6;
    localparam logic [7:0] CMD_VMIN = 8'hD7;
    localparam logic [7:0] CMD_TAVG = 8'hE3;

    // ----------------------------------------
    // Mode register fields
    // ----------------------------------------
    localparam int MODE_SEQ_BIT = 12;
    localparam int MODE_DUAL_BIT = 5;
    localparam int MODE_IGN1_BIT = 4;
    localparam int MODE_AVG_LSB = 2;
    localparam int MODE_IGN2_BIT = 1;
    localparam int MODE_CLR_BIT = 0;
    localparam logic [15:0] MODE_MASK = 16'h103F;
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // ----------------------------------------
    // Enable output and slot fields
    // ----------------------------------------
    localparam int EN_DRIVE_BIT = 7;
    localparam int EN_POL_BIT = 6;
    localparam int EN_OVR_BIT = 0;
    localparam logic [7:0] EN_MASK = 8'hC1;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam int SLOT_GROUP_BIT = 5;
    localparam logic [7:0] SLOT_MASK = 8'h2F;
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [3:0] SLOT_LAST = 4'hB;

    // ----------------------------------------
    // Statistics reset values
    // ----------------------------------------
    localparam logic [15:0] VPEAK_RESET = 16'h0000;
    localparam logic [15:0] TPEAK_RESET = 16'h8000;
    localparam logic [15:0] VMIN_RESET = 16'h7FFF;
    localparam logic [15:0] TAVG_RESET = 16'h0000;
    localparam int TAVG_SHIFT = 3;

    // ----------------------------------------
    // Carriers and states
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [PAGE_W-1:0] page;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic unmapped;
        logic [15:0] data;
    } rsp_t;

    typedef struct packed {
        logic vout_valid;
        logic [PAGE_W-1:0] page;
        logic [15:0] vout;
        logic temp_valid;
        logic [15:0] temp;
    } meas_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_t;

    typedef enum logic [1:0] {
        CLR_IDLE = 2'b01,
        CLR_BUSY = 2'b10
    } clr_state_t;

endpackage

// ===== rtl/level_sync.sv
module level_sync #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clock_en,
    // Async level in, synced level out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t cur_reg;
    sync_t cur_next;

    // Two stages; the first is read only by the second
    always_comb
    begin
        cur_next.s1 = i_async;
        cur_next.s2 = cur_reg.s1;
    end

    // Pins idle high
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            cur_reg <= '1;
        else if (i_clock_en)
            cur_reg <= cur_next;
    end

    assign o_sync = cur_reg.s2;

endmodule

// ===== rtl/enable_pin_driver.sv
module enable_pin_driver (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clock_en,
    // Channel configuration and request
    input wire logic [7:0] i_config,
    input wire logic i_enable,
    // Pin
    output logic o_out,
    output logic o_oe
);

    seq_regs_pkg::pin_t pin_reg;
    seq_regs_pkg::pin_t pin_next;
    logic level;

    // Pin level, then the drive style
    always_comb
    begin
        level = 1'b0;
        if (i_config[seq_regs_pkg::EN_OVR_BIT])
            level = i_config[seq_regs_pkg::EN_POL_BIT];
        else if (i_enable)
            level = i_config[seq_regs_pkg::EN_POL_BIT];
        else
            level = !i_config[seq_regs_pkg::EN_POL_BIT];
        if (i_config[seq_regs_pkg::EN_DRIVE_BIT])
        begin
            // Open drain: pull low only
            pin_next.out = 1'b0;
            pin_next.oe = !level;
        end
        else
        begin
            // Push-pull: always driven
            pin_next.out = level;
            pin_next.oe = 1'b1;
        end
    end

    // Released during reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            pin_reg <= '0;
        else if (i_clock_en)
            pin_reg <= pin_next;
    end

    assign o_out = pin_reg.out;
    assign o_oe = pin_reg.oe;

endmodule

// ===== sim/pmbus_host_model.sv
module pmbus_host_model (
    // Clock
    input wire logic i_clock,
    // Decoded command out
    output seq_regs_pkg::cmd_t o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle until the first command
    initial o_cmd = '0;

    // One command, valid for one cycle; enable config only with supplies off
    // Global channels are only placed from slot 0 upward
    task automatic send(input logic w, input logic [7:0] c, input logic [3:0] p,
                        input logic [15:0] d);
        @(posedge i_clock);
        o_cmd <= {1'b1, w, c, p, d};
        @(posedge i_clock);
        o_cmd.valid <= 1'b0;
    endtask
endmodule

// ===== sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    seq_regs_pkg::cmd_t cmd;
    seq_regs_pkg::rsp_t rsp;
    seq_regs_pkg::meas_t meas = '0;
    logic pf_n = 1'b1;
    logic sf_n = 1'b1;
    logic [11:0] glob = '0;
    logic [11:0] on = '0;
    logic al_a = 1'b0;
    logic al_b = 1'b0;
    logic [11:0] en_out, en_oe, ch_shut, slot_act, grp2;
    logic out_a, out_b, p_shut, s_shut, seq_sel, dual, lvl;
    logic [3:0] avg;
    logic [11:0][3:0] slot;
    logic [7:0] c;
    logic [17:0] e;
    // Expected answers: check flag, unmapped, data
    logic [17:0] exp_q[$];
    logic [7:0] codes [7] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7, 8'hE3};
    logic [15:0] rstv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000,
                              16'h7FFF, 16'h0000};
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'hec46_6ec6;

    // 100 MHz clock
    always #5 i_clock = ~i_clock;

    pmbus_host_model u_host (.i_clock(i_clock), .o_cmd(cmd));

    seq_cfg_peak_regs u_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clock_en(1'b1), .i_cmd(cmd),
        .o_rsp(rsp), .i_meas(meas), .i_primary_fault_pin_n(pf_n),
        .i_secondary_fault_pin_n(sf_n), .i_channel_global(glob), .i_supply_on(on),
        .i_alarm_a_set(al_a), .i_alarm_b_set(al_b), .o_supply_enable_out(en_out),
        .o_supply_enable_oe(en_oe), .o_alarm_output_a(out_a), .o_alarm_output_b(out_b),
        .o_primary_shutdown(p_shut), .o_secondary_shutdown(s_shut),
        .o_channel_shutdown(ch_shut), .o_sequencing_mode_select(seq_sel),
        .o_two_group_sequencing(dual), .o_adc_average_samples(avg), .o_slot_code(slot),
        .o_slot_active(slot_act), .o_group_secondary(grp2));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        checked++;
        if (g !== x)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic rd(input logic [7:0] cd, input logic [3:0] p, input logic [15:0] x,
                      input logic u);
        exp_q.push_back({1'b1, u, x});
        u_host.send(1'b0, cd, p, 16'h0000);
    endtask

    task automatic wr(input logic [7:0] cd, input logic [3:0] p, input logic [15:0] d);
        exp_q.push_back(18'h00000);
        u_host.send(1'b1, cd, p, d);
    endtask

    // Voltage sample when v is 1, temperature otherwise
    task automatic mv(input logic v, input logic [3:0] p, input logic [15:0] d);
        @(posedge i_clock);
        meas <= {v, p, d, ~v, d};
        @(posedge i_clock);
        meas <= '0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Answer watcher, takes the oldest note per response
    always @(negedge i_clock)
    begin
        if (rsp.valid === 1'b1)
        begin
            e = exp_q.pop_front();
            chk("unmapped", {15'h0, e[16]}, {15'h0, rsp.unmapped});
            if (e[17])
                chk("read data", e[15:0], rsp.data);
        end
    end

    // Hang guard
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(codes[i], 4'h0, rstv[i], 1'b0);
        rd(8'h00, 4'h0, 16'h0000, 1'b1);
        rd(8'hD4, 4'hC, 16'h0000, 1'b1);
        wr(8'hD2, 4'h5, 16'h00FF);
        rd(8'hD2, 4'h5, 16'h00C1, 1'b0);
        rd(8'hD2, 4'h6, 16'h0000, 1'b0);
        wr(8'hD3, 4'h5, 16'h00FF);
        rd(8'hD3, 4'h5, 16'h002F, 1'b0);
        // Every enable config, supply off and on
        for (int k = 0; k < 16; k++)
        begin
            c = {k[2], k[1], 5'h00, k[0]};
            @(posedge i_clock);
            on <= '0;
            wr(8'hD2, 4'h0, {8'h00, c});
            on[0] <= k[3];
            wt(3);
            lvl = c[0] ? c[6] : ~(k[3] ^ c[6]);
            chk("enable out", c[7] ? 1'b0 : lvl, en_out[0]);
            chk("enable oe", {15'h0000, c[7] ? ~lvl : 1'b1}, en_oe[0]);
        end
        // Mode fields and slot codes around the last legal one
        for (int n = 0; n < 4; n++)
        begin
            wr(8'hD1, 4'h0, {3'h0, n[0], 6'h00, n[1], 1'b0, n[1:0], 2'b00});
            wr(8'hD3, 4'h1, {10'h000, 2'b10, 4'hA + 4'(n)});
            wt(2);
            chk("average", 16'h0001 << n, avg);
            chk("seq mode", n[0], seq_sel);
            chk("dual", n[1], dual);
            chk("slot code", 4'hA + 4'(n), slot[1]);
            chk("slot active", n[0] && (n < 2), slot_act[1]);
            chk("group", n[1], grp2[1]);
        end
        // Fault pins against ignore bits, random global mask
        for (int f = 0; f < 4; f++)
        begin
            lfsr = nxt(lfsr);
            wr(8'hD1, 4'h0, {11'h000, f[0], 2'b00, f[1], 1'b0});
            glob <= lfsr[11:0];
            pf_n <= 1'b0;
            sf_n <= 1'b0;
            wt(4);
            chk("primary shutdown", {15'h0000, ~f[0]}, p_shut);
            chk("secondary shutdown", {15'h0000, ~f[1]}, s_shut);
            chk("channels", f[0] ? 12'h000 : lfsr[11:0], ch_shut);
            @(posedge i_clock);
            pf_n <= 1'b1;
            sf_n <= 1'b1;
            wt(4);
            chk("primary release", 1'b0, p_shut);
        end
        // Alarm raise and clear
        @(posedge i_clock);
        al_a <= 1'b1;
        al_b <= 1'b1;
        @(posedge i_clock);
        al_a <= 1'b0;
        al_b <= 1'b0;
        wt(2);
        chk("alarms set", 2'b11, {out_a, out_b});
        wr(8'hD1, 4'h0, 16'h0001);
        wt(2);
        chk("alarms clear", 2'b00, {out_a, out_b});
        rd(8'hD1, 4'h0, 16'h0000, 1'b0);
        // Statistics
        wr(8'hD4, 4'h3, 16'h0000);
        mv(1'b1, 4'h3, 16'h0100);
        mv(1'b1, 4'h3, 16'h0050);
        rd(8'hD4, 4'h3, 16'h0100, 1'b0);
        wr(8'hD4, 4'h3, 16'h0200);
        mv(1'b1, 4'h3, 16'h0150);
        rd(8'hD4, 4'h3, 16'h0200, 1'b0);
        wr(8'hD7, 4'h3, 16'h7FFF);
        mv(1'b1, 4'h3, 16'h0050);
        mv(1'b1, 4'h3, 16'h0100);
        rd(8'hD7, 4'h3, 16'h0050, 1'b0);
        wr(8'hD6, 4'h0, 16'h8000);
        mv(1'b0, 4'h0, 16'hFF00);
        rd(8'hD6, 4'h0, 16'hFF00, 1'b0);
        wr(8'hE3, 4'h0, 16'h0000);
        mv(1'b0, 4'h0, 16'h0123);
        rd(8'hE3, 4'h0, 16'h0123, 1'b0);
        wr(8'hE3, 4'h0, 16'h0055);
        rd(8'hE3, 4'h0, 16'h0123, 1'b0);
        repeat (5) @(posedge i_clock);
        chk("pending answers", 16'h0000, 16'(exp_q.size()));
        tally_and_finish();
    end
endmodule
